// ===== logic/diag_cfg_pkg.sv
package diag_cfg_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  GLOBAL_CONFIGURATION_OFFSET = 8'h00;
  localparam logic [31:0] GLOBAL_CONFIGURATION_RESET  = 32'h0000_0002;
  // only these bits are held; the rest read as zero
  localparam logic [31:0] GLOBAL_CONFIGURATION_MASK   = 32'h6000_03FF;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int AXIS0_SILENT_CHOPPER_ENABLE_BIT = 0;
  localparam int AXIS0_PULSE_FILTER_ENABLE_BIT   = 1;
  localparam int AXIS0_DIRECTION_INVERT_BIT      = 2;
  localparam int PIN_A_DRIVER_FAULT_BIT          = 3;
  localparam int PIN_A_OVERTEMP_WARNING_BIT      = 4;
  localparam int PIN_A_STALL_OR_PULSE_BIT        = 5;
  localparam int PIN_B_STALL_OR_DIRECTION_BIT    = 6;
  localparam int AXIS0_INDEX_TO_PIN_B_BIT        = 7;
  localparam int PIN_A_DRIVE_TYPE_BIT            = 8;
  localparam int PIN_B_DRIVE_TYPE_BIT            = 9;
  localparam int PIN_A_SOURCE_SELECT_BIT         = 29;
  localparam int PIN_B_SOURCE_SELECT_BIT         = 30;

  // ****************************************************************
  // event carrier from the motion and driver logic
  // ****************************************************************
  typedef struct packed {
    logic stall;
    logic index;
    logic position_compare;
    logic motion_interrupt;
    logic ramp_step;
    logic ramp_direction;
    logic overtemp_warning;
    logic overtemp;
    logic short_to_ground;
  } event_in_s;

endpackage

// ===== logic/diag_output_global_config.sv
module diag_output_global_config (
  input  wire logic                    MCLK,
  input  wire logic                    RST_N,
  input  wire logic                    REG_WR_EN,
  input  wire logic                    REG_RD_EN,
  input  wire logic [7:0]              REG_ADDR,
  input  wire logic [31:0]             REG_WDATA,
  output logic      [31:0]             REG_RDATA,
  input  wire diag_cfg_pkg::event_in_s EVENTS,
  output logic                         FAULT_PIN_A_O,
  output logic                         FAULT_PIN_A_OE,
  output logic                         FAULT_PIN_B_O,
  output logic                         FAULT_PIN_B_OE,
  output logic                         AXIS0_DIRECTION_INVERT,
  output logic                         AXIS0_PULSE_FILTER_ENABLE,
  output logic                         AXIS0_SILENT_CHOPPER_ENABLE
);

  // ****************************************************************
  // configuration register
  // ****************************************************************
  logic [31:0] config_ff;
  logic        hit;

  assign hit = (REG_ADDR == diag_cfg_pkg::GLOBAL_CONFIGURATION_OFFSET);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      config_ff <= diag_cfg_pkg::GLOBAL_CONFIGURATION_RESET;
    end else if (REG_WR_EN && hit) begin
      config_ff <= REG_WDATA & diag_cfg_pkg::GLOBAL_CONFIGURATION_MASK;
    end
  end

  // read answer one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD_EN) begin
      REG_RDATA <= hit ? config_ff : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // axis 0 controls
  // ****************************************************************
  assign AXIS0_DIRECTION_INVERT      = config_ff[diag_cfg_pkg::AXIS0_DIRECTION_INVERT_BIT];
  assign AXIS0_PULSE_FILTER_ENABLE   = config_ff[diag_cfg_pkg::AXIS0_PULSE_FILTER_ENABLE_BIT];
  assign AXIS0_SILENT_CHOPPER_ENABLE = config_ff[diag_cfg_pkg::AXIS0_SILENT_CHOPPER_ENABLE_BIT];

  // ****************************************************************
  // pin source selection
  // ****************************************************************
  logic sel_a;
  logic sel_b;
  logic mode_a;
  logic mode_b;
  logic nxt_pin_a_active;
  logic nxt_pin_b_active;

  assign sel_a  = config_ff[diag_cfg_pkg::PIN_A_SOURCE_SELECT_BIT];
  assign sel_b  = config_ff[diag_cfg_pkg::PIN_B_SOURCE_SELECT_BIT];
  assign mode_a = config_ff[diag_cfg_pkg::PIN_A_STALL_OR_PULSE_BIT];
  assign mode_b = config_ff[diag_cfg_pkg::PIN_B_STALL_OR_DIRECTION_BIT];

  always_comb begin
    nxt_pin_a_active = 1'b0;
    if (!sel_a && mode_a && EVENTS.stall) begin
      nxt_pin_a_active = 1'b1;
    end
    if (sel_a && !mode_a && EVENTS.motion_interrupt) begin
      nxt_pin_a_active = 1'b1;
    end
    if (sel_a && mode_a && EVENTS.ramp_step) begin
      nxt_pin_a_active = 1'b1;
    end
    if (config_ff[diag_cfg_pkg::PIN_A_OVERTEMP_WARNING_BIT] && EVENTS.overtemp_warning) begin
      nxt_pin_a_active = 1'b1;
    end
    if (config_ff[diag_cfg_pkg::PIN_A_DRIVER_FAULT_BIT] && (EVENTS.overtemp || EVENTS.short_to_ground)) begin
      nxt_pin_a_active = 1'b1;
    end
  end

  always_comb begin
    nxt_pin_b_active = 1'b0;
    if (config_ff[diag_cfg_pkg::AXIS0_INDEX_TO_PIN_B_BIT] && EVENTS.index) begin
      nxt_pin_b_active = 1'b1;
    end
    if (!sel_b && mode_b && EVENTS.stall) begin
      nxt_pin_b_active = 1'b1;
    end
    if (sel_b && !mode_b && EVENTS.position_compare) begin
      nxt_pin_b_active = 1'b1;
    end
    if (sel_b && mode_b && EVENTS.ramp_direction) begin
      nxt_pin_b_active = 1'b1;
    end
  end

  // ****************************************************************
  // pin output stages
  // ****************************************************************
  logic pin_a_active_ff;
  logic pin_b_active_ff;

  // pin A held active while reset is low
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_a_active_ff <= 1'b1;
    end else begin
      pin_a_active_ff <= nxt_pin_a_active;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_b_active_ff <= 1'b0;
    end else begin
      pin_b_active_ff <= nxt_pin_b_active;
    end
  end

  // reset forces push-pull low on pin A regardless of drive type
  assign FAULT_PIN_A_O  = 1'b0 | (!pin_a_active_ff && config_ff[diag_cfg_pkg::PIN_A_DRIVE_TYPE_BIT]);
  assign FAULT_PIN_A_OE = pin_a_active_ff || config_ff[diag_cfg_pkg::PIN_A_DRIVE_TYPE_BIT];
  assign FAULT_PIN_B_O  = !pin_b_active_ff && config_ff[diag_cfg_pkg::PIN_B_DRIVE_TYPE_BIT];
  assign FAULT_PIN_B_OE = pin_b_active_ff || config_ff[diag_cfg_pkg::PIN_B_DRIVE_TYPE_BIT];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // field views for the checks
  logic drive_a;
  logic drive_b;
  logic index_en;
  logic prewarn_en;
  logic fault_en;
  logic wdata_dir;
  logic wdata_filt;
  logic wdata_chop;

  assign drive_a    = config_ff[diag_cfg_pkg::PIN_A_DRIVE_TYPE_BIT];
  assign drive_b    = config_ff[diag_cfg_pkg::PIN_B_DRIVE_TYPE_BIT];
  assign index_en   = config_ff[diag_cfg_pkg::AXIS0_INDEX_TO_PIN_B_BIT];
  assign prewarn_en = config_ff[diag_cfg_pkg::PIN_A_OVERTEMP_WARNING_BIT];
  assign fault_en   = config_ff[diag_cfg_pkg::PIN_A_DRIVER_FAULT_BIT];
  assign wdata_dir  = REG_WDATA[diag_cfg_pkg::AXIS0_DIRECTION_INVERT_BIT];
  assign wdata_filt = REG_WDATA[diag_cfg_pkg::AXIS0_PULSE_FILTER_ENABLE_BIT];
  assign wdata_chop = REG_WDATA[diag_cfg_pkg::AXIS0_SILENT_CHOPPER_ENABLE_BIT];

  sequence cfg_write_s;
    REG_WR_EN && hit;
  endsequence

  sequence a_fault_event_s;
    fault_en && (EVENTS.overtemp || EVENTS.short_to_ground);
  endsequence

  sequence b_sources_off_s;
    !index_en && !mode_b && !sel_b;
  endsequence

  pin_b_drive_a : assert property ((!pin_b_active_ff && drive_b) |-> (FAULT_PIN_B_OE && FAULT_PIN_B_O))
    else $error("pin B push-pull not high when idle");
  pin_b_open_a : assert property ((!pin_b_active_ff && !drive_b) |-> !FAULT_PIN_B_OE)
    else $error("pin B open drain not released");
  pin_a_open_a : assert property ((!pin_a_active_ff && !drive_a) |-> !FAULT_PIN_A_OE)
    else $error("pin A open drain not released");
  pin_a_drive_a : assert property ((!pin_a_active_ff && drive_a) |-> (FAULT_PIN_A_OE && FAULT_PIN_A_O))
    else $error("pin A push-pull not high when idle");
  pin_a_low_a : assert property (pin_a_active_ff |-> (FAULT_PIN_A_OE && !FAULT_PIN_A_O))
    else $error("active pin A not pulled low");
  pin_b_low_a : assert property (pin_b_active_ff |-> (FAULT_PIN_B_OE && !FAULT_PIN_B_O))
    else $error("active pin B not pulled low");
  index_pin_b_a : assert property ((index_en && EVENTS.index) |=> (FAULT_PIN_B_OE && !FAULT_PIN_B_O))
    else $error("index not shown on pin B");
  pin_b_quiet_a : assert property (b_sources_off_s |=> !pin_b_active_ff)
    else $error("pin B active with all sources off");
  stall_pin_b_a : assert property ((!sel_b && mode_b && EVENTS.stall) |=> !FAULT_PIN_B_O)
    else $error("stall not shown on pin B");
  poscomp_b_a : assert property ((sel_b && !mode_b && EVENTS.position_compare) |=> pin_b_active_ff)
    else $error("position compare not shown on pin B");
  direction_b_a : assert property ((sel_b && mode_b && EVENTS.ramp_direction) |=> pin_b_active_ff)
    else $error("ramp direction not shown on pin B");
  stall_pin_a_a : assert property ((!sel_a && mode_a && EVENTS.stall) |=> !FAULT_PIN_A_O)
    else $error("stall not shown on pin A");
  interrupt_a_a : assert property ((sel_a && !mode_a && EVENTS.motion_interrupt) |=> pin_a_active_ff)
    else $error("motion interrupt not shown on pin A");
  step_pin_a_a : assert property ((sel_a && mode_a && EVENTS.ramp_step) |=> pin_a_active_ff)
    else $error("ramp step not shown on pin A");
  prewarn_a_a : assert property ((prewarn_en && EVENTS.overtemp_warning) |=> pin_a_active_ff)
    else $error("prewarning not shown on pin A");
  fault_pin_a_a : assert property ((!fault_en && !prewarn_en && !mode_a && !sel_a) |=> !pin_a_active_ff)
    else $error("pin A active with all sources off");
  driver_fault_a : assert property (a_fault_event_s |=> pin_a_active_ff)
    else $error("driver fault not shown on pin A");
  reset_pin_a_a : assert property (@(posedge MCLK) disable iff (1'b0) !RST_N |-> FAULT_PIN_A_OE && !FAULT_PIN_A_O)
    else $error("pin A not active during reset");
  direction_cfg_a : assert property (cfg_write_s |=> (AXIS0_DIRECTION_INVERT == $past(wdata_dir)))
    else $error("direction invert not written");
  filter_cfg_a : assert property (cfg_write_s |=> (AXIS0_PULSE_FILTER_ENABLE == $past(wdata_filt)))
    else $error("filter enable not written");
  chopper_wr_a : assert property (cfg_write_s |=> (AXIS0_SILENT_CHOPPER_ENABLE == $past(wdata_chop)))
    else $error("chopper enable not written");
  chopper_cfg_a : assert property (cfg_write_s ##1 !REG_WR_EN |=> $stable(AXIS0_SILENT_CHOPPER_ENABLE))
    else $error("chopper enable changed without write");

endmodule

// ===== testbench/fault_line_model.sv
module fault_line_model (
  input  wire logic pin_a_o,
  input  wire logic pin_a_oe,
  input  wire logic pin_b_o,
  input  wire logic pin_b_oe,
  output logic      pin_a_level,
  output logic      pin_b_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // released line floats to the pull-up level
  assign pin_a_level = pin_a_oe ? pin_a_o : 1'b1;
  assign pin_b_level = pin_b_oe ? pin_b_o : 1'b1;
endmodule

// ===== testbench/tb_diag_output_global_config.sv
module tb_diag_output_global_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    mclk = 1'b0;
  logic                    rst_n = 1'b1;
  logic                    wr_en = 1'b0;
  logic                    rd_en = 1'b0;
  logic [7:0]              addr = 8'h00;
  logic [31:0]             wdata = 32'h0000_0000;
  logic [31:0]             rdata;
  diag_cfg_pkg::event_in_s events = '0;
  logic                    a_o, a_oe, b_o, b_oe, a_lvl, b_lvl, inv, filt, chop;
  int                      miscompares = 0;
  int                      tests_run = 0;

  always #25 mclk = ~mclk;

  diag_output_global_config DUT (.MCLK(mclk), .RST_N(rst_n), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .EVENTS(events), .FAULT_PIN_A_O(a_o),
    .FAULT_PIN_A_OE(a_oe), .FAULT_PIN_B_O(b_o), .FAULT_PIN_B_OE(b_oe), .AXIS0_DIRECTION_INVERT(inv),
    .AXIS0_PULSE_FILTER_ENABLE(filt), .AXIS0_SILENT_CHOPPER_ENABLE(chop));

  fault_line_model far_side (.pin_a_o(a_o), .pin_a_oe(a_oe), .pin_b_o(b_o), .pin_b_oe(b_oe),
    .pin_a_level(a_lvl), .pin_b_level(b_lvl));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    #1 chk("readback", exp, rdata);
  endtask

  task automatic axis(input logic [2:0] exp);
    #1 chk("axis_outputs", {29'h0, exp}, {29'h0, inv, filt, chop});
  endtask

  task automatic pin_case(input logic [31:0] cfg, input logic [8:0] ev, input logic la, input logic lb);
    wr(8'h00, cfg);
    events <= diag_cfg_pkg::event_in_s'(ev);
    repeat (2) @(posedge mclk);
    #1 chk("pin_a_level", {31'h0, la}, {31'h0, a_lvl});
    chk("pin_b_level", {31'h0, lb}, {31'h0, b_lvl});
    @(posedge mclk);
    events <= '0;
  endtask

  task automatic conclude;
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    conclude();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // falling edge at time zero so the asynchronous reset really fires
  task automatic reset_case;
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    #1 chk("pin_a_in_reset", 32'h1, {31'h0, a_oe & ~a_o});
    chk("pin_b_in_reset", 32'h1, {31'h0, b_lvl});
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_0002);
    axis(3'b010);
  endtask

  task automatic register_case;
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h6000_03FF);
    axis(3'b111);
    wr(8'h00, 32'h0000_0300);
    repeat (2) @(posedge mclk);
    #1 chk("push_pull_idle", 32'hF, {28'h0, a_oe, a_o, b_oe, b_o});
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_0300);
    rd(8'h04, 32'h0000_0000);
    axis(3'b000);
  endtask

  task automatic pin_source_case;
    pin_case(32'h0000_0000, 9'h100, 1'b1, 1'b1);
    pin_case(32'h0000_0020, 9'h100, 1'b0, 1'b1);
    pin_case(32'h0000_0040, 9'h100, 1'b1, 1'b0);
    pin_case(32'h0000_0080, 9'h080, 1'b1, 1'b0);
    pin_case(32'h4000_0000, 9'h040, 1'b1, 1'b0);
    pin_case(32'h4000_0040, 9'h008, 1'b1, 1'b0);
    pin_case(32'h2000_0000, 9'h020, 1'b0, 1'b1);
    pin_case(32'h2000_0020, 9'h010, 1'b0, 1'b1);
    pin_case(32'h0000_0010, 9'h004, 1'b0, 1'b1);
    pin_case(32'h0000_0008, 9'h002, 1'b0, 1'b1);
    pin_case(32'h0000_0008, 9'h001, 1'b0, 1'b1);
    pin_case(32'h0000_0000, 9'h007, 1'b1, 1'b1);
  endtask

  task automatic midrun_reset_case;
    wr(8'h00, 32'h0000_0300);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1 chk("pin_a_mid_reset", 32'h1, {31'h0, a_oe & ~a_o});
    @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 chk("pin_a_after_reset", 32'h1, {31'h0, a_lvl});
    rd(8'h00, 32'h0000_0002);
  endtask

  initial begin
    reset_case();
    register_case();
    pin_source_case();
    midrun_reset_case();
    conclude();
  end
endmodule
